// >>> design/etsa_pkg.sv
// Package for the transmit statistics and station address register block
// Function
// - Count frames sent without failure
// - Count good frames after two+ collisions
// - Base-word read clears counter unless bytes 0/1 off
// - Receive traffic never changes the counters
// - Bits 31-16 read zero, writes ignored
// - Address bits 15-8 hold fourth octet
// - Address bits 7-0 hold third octet
// - Address takes 16/32-bit accesses, ignores 8-bit
// - Address loads factory value at reset
`default_nettype none
package etsa_pkg;
  // Register block layout: base word followed by clear, set and invert aliases
  localparam logic [7:0] ETSA_OFS_TXOK      = 8'h00;
  localparam logic [7:0] ETSA_OFS_MCOL      = 8'h10;
  localparam logic [7:0] ETSA_OFS_SADDR     = 8'h20;
  localparam logic [3:0] ETSA_ALIAS_BASE    = 4'h0;
  localparam logic [3:0] ETSA_ALIAS_CLR     = 4'h4;
  localparam logic [3:0] ETSA_ALIAS_SET     = 4'h8;
  localparam logic [3:0] ETSA_ALIAS_INV     = 4'hc;
  localparam int         ETSA_FIELD_W       = 16;
  localparam logic [15:0] ETSA_CNT_RESET    = 16'h0000;
  localparam logic [15:0] ETSA_FACTORY_ADDR = 16'h5a3c; // Arbitrary default
  localparam logic [1:0] ETSA_TRANS_NONSEQ  = 2'h2;
  localparam logic [1:0] ETSA_TRANS_SEQ     = 2'h3;
  localparam logic [2:0] ETSA_SIZE_BYTE     = 3'h0;
  localparam logic [2:0] ETSA_SIZE_HALF     = 3'h1;
  localparam logic [2:0] ETSA_SIZE_WORD     = 3'h2;

  // Alias operation selected by the low address nibble
  typedef enum logic [1:0] {ETSA_OP_WRITE, ETSA_OP_CLR, ETSA_OP_SET, ETSA_OP_INV} etsa_op_t;

  // Apply an alias operation to a 16-bit field under a bit-write mask
  function automatic logic [15:0] etsa_apply(input logic [15:0] cur, input logic [15:0] wd,
                                             input logic [15:0] msk, input etsa_op_t op);
    logic [15:0] r;
    r = cur;
    case (op)
      ETSA_OP_WRITE: r = (cur & ~msk) | (wd & msk);
      ETSA_OP_CLR:   r = cur & ~(wd & msk);
      ETSA_OP_SET:   r = cur | (wd & msk);
      ETSA_OP_INV:   r = cur ^ (wd & msk);
      default:       r = cur;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> design/etsa_regs.sv
// AHB-Lite register block: transmit statistics counters and station address
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module etsa_regs
  import etsa_pkg::*;
#(
  parameter logic [15:0] FACTORY_ADDR = ETSA_FACTORY_ADDR
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        factory_addr_valid,
  input  wire logic [15:0] factory_addr,
  input  wire logic        tx_frame_ok,
  input  wire logic        tx_multi_collision,
  output logic      [7:0]  addr_octet_third,
  output logic      [7:0]  addr_octet_fourth
);
  // Address-phase capture
  logic       dp_valid;
  logic       dp_write;
  logic [7:0] dp_addr;
  logic [2:0] dp_size;
  logic       strap_pending;
  logic       raw_stalled;
  logic [15:0] station_address_mid;
  logic [15:0] tx_ok_count_field;
  logic [15:0] multi_collision_count_field;

  // Register selected by a byte address
  function automatic logic [1:0] etsa_reg_sel(input logic [7:0] a);
    logic [1:0] s;
    s = 2'h3;
    case (a & 8'hf0)
      ETSA_OFS_TXOK:  s = 2'h0;
      ETSA_OFS_MCOL:  s = 2'h1;
      ETSA_OFS_SADDR: s = 2'h2;
      default:        s = 2'h3;
    endcase
    return s;
  endfunction

  // Byte-lane mask of the low 16 bits touched by a transfer
  function automatic logic [1:0] etsa_lanes(input logic [7:0] a, input logic [2:0] sz);
    logic [1:0] l;
    l = 2'h0;
    case (sz)
      ETSA_SIZE_WORD: l = 2'h3;
      ETSA_SIZE_HALF: l = (a[1] == 1'b0) ? 2'h3 : 2'h0;
      ETSA_SIZE_BYTE: l = (a[1:0] == 2'h0) ? 2'h1 : ((a[1:0] == 2'h1) ? 2'h2 : 2'h0);
      default:        l = 2'h0;
    endcase
    return l;
  endfunction

  wire logic     take     = hsel && hready && (htrans == ETSA_TRANS_NONSEQ ||
                                               htrans == ETSA_TRANS_SEQ);
  wire logic [1:0] sel    = etsa_reg_sel(dp_addr);
  wire logic [1:0] lanes  = etsa_lanes(dp_addr, dp_size);
  wire logic [15:0] msk   = {{8{lanes[1]}}, {8{lanes[0]}}};
  wire logic [15:0] wdat  = dp_addr[1] ? hwdata[31:16] : hwdata[15:0];
  wire logic [3:0] asub   = dp_addr[3:0] & 4'hc;
  etsa_op_t op;

  // Alias decode from the word index inside a register's block
  always_comb begin
    case (asub)
      ETSA_ALIAS_CLR: op = ETSA_OP_CLR;
      ETSA_ALIAS_SET: op = ETSA_OP_SET;
      ETSA_ALIAS_INV: op = ETSA_OP_INV;
      default:        op = ETSA_OP_WRITE;
    endcase
  end

  // A read address phase behind a write data phase waits one cycle, so the write lands
  // before the read data is captured; a pipelined master would otherwise read stale data
  wire logic raw_hit  = dp_valid && dp_write && hsel && !hwrite &&
                        (htrans == ETSA_TRANS_NONSEQ || htrans == ETSA_TRANS_SEQ);
  // The write is applied in the first data-phase cycle only, never twice across a stall
  wire logic wr_cyc   = clk_en && dp_valid && dp_write && !raw_stalled;
  // Address-phase view of a read: a counter is cleared on the edge that captures it
  wire logic       rd_take = take && !hwrite;
  wire logic [1:0] a_sel   = etsa_reg_sel(haddr);
  wire logic [1:0] a_lanes = etsa_lanes(haddr, hsize);
  wire logic       a_base  = (haddr[3:0] & 4'hc) == ETSA_ALIAS_BASE;
  // Byte accesses never reach the station address
  wire logic sa_wr    = wr_cyc && sel == 2'h2 && dp_size != ETSA_SIZE_BYTE;
  wire logic ok_wr    = wr_cyc && sel == 2'h0;
  wire logic mc_wr    = wr_cyc && sel == 2'h1;
  // Reads of the base word only clear, and only if a low lane is enabled; clearing on
  // the capture edge loses at most a frame event of that very cycle
  wire logic rd_clr   = clk_en && rd_take && a_base && a_lanes != 2'h0;

  // Transfers complete in one data-phase cycle with OKAY, bar the one-cycle stall
  assign hreadyout = !(raw_hit && !raw_stalled);
  assign hresp     = 1'b0;

  // Address phase is latched on the edge where hready is high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      dp_size  <= ETSA_SIZE_BYTE;
    end else if (clk_en && hready) begin
      dp_valid <= take;
      dp_write <= hwrite;
      dp_addr  <= haddr;
      dp_size  <= hsize;
    end
  end

  // Marks the stall cycle as spent, so the held read is taken on the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      raw_stalled <= 1'b0;
    end else if (clk_en) begin
      raw_stalled <= raw_hit && !raw_stalled;
    end
  end

  // Read data registered at the address phase so it stands for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clk_en && hready) begin
      hrdata <= 32'h0000_0000; // Upper half and unmapped words read zero
      if (rd_take) begin
        case (a_sel)
          2'h0:    hrdata[15:0] <= tx_ok_count_field;
          2'h1:    hrdata[15:0] <= multi_collision_count_field;
          2'h2:    hrdata[15:0] <= (hsize == ETSA_SIZE_BYTE) ? 16'h0000 : station_address_mid;
          default: hrdata[15:0] <= 16'h0000;
        endcase
      end
    end
  end

  // Factory value is strapped in after reset release, since an async reset may only load constants
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_pending       <= 1'b1;
      station_address_mid <= FACTORY_ADDR;
    end else if (clk_en) begin
      if (strap_pending && factory_addr_valid) begin
        strap_pending       <= 1'b0;
        station_address_mid <= factory_addr;
      end else if (sa_wr) begin
        station_address_mid <= etsa_apply(station_address_mid, wdat, msk, op);
      end
    end
  end

  // Octets as they leave on the wire
  assign addr_octet_third  = station_address_mid[7:0];
  assign addr_octet_fourth = station_address_mid[15:8];

  // Only transmit-side events feed the counters
  etsa_stat_counter u_txok (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .count_evt (tx_frame_ok),
    .wr_en     (ok_wr),
    .wr_op     (op),
    .wr_data   (wdat),
    .wr_mask   (msk),
    .rd_clear  (rd_clr && a_sel == 2'h0),
    .count     (tx_ok_count_field)
  );

  etsa_stat_counter u_mcol (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .count_evt (tx_frame_ok && tx_multi_collision),
    .wr_en     (mc_wr),
    .wr_op     (op),
    .wr_data   (wdat),
    .wr_mask   (msk),
    .rd_clear  (rd_clr && a_sel == 2'h1),
    .count     (multi_collision_count_field)
  );

  chk_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    hrdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_byte_ignore: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_cyc && sel == 2'h2 && dp_size == ETSA_SIZE_BYTE && !strap_pending)
    |=> $stable(station_address_mid))
    else $error("byte write changed station address");
  chk_strap_load: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && strap_pending && factory_addr_valid) |=>
    (station_address_mid == $past(factory_addr) && !strap_pending))
    else $error("factory address not loaded");
  chk_mcol_subset: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && tx_multi_collision && !tx_frame_ok && !mc_wr && !rd_clr)
    |=> $stable(multi_collision_count_field))
    else $error("collision counted without good frame");
  chk_set_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (sa_wr && !strap_pending && op == ETSA_OP_SET) |=>
    ((station_address_mid & $past(wdat & msk)) == $past(wdat & msk)))
    else $error("set alias did not set bits");
  chk_octet_map: assert property (@(posedge hclk) disable iff (!hresetn)
    (sa_wr && !strap_pending && op == ETSA_OP_WRITE && msk == '1) |=>
    (addr_octet_fourth == $past(wdat[15:8]) && addr_octet_third == $past(wdat[7:0])))
    else $error("octet outputs misplaced");

  // Read-clear of each counter, seen on its capture edge
  sequence seq_txok_clear;
    rd_clr && a_sel == 2'h0;
  endsequence
  sequence seq_mcol_clear;
    rd_clr && a_sel == 2'h1;
  endsequence
  // Frame events that no bus access of the same cycle can mask
  sequence seq_txok_event;
    clk_en && tx_frame_ok && !ok_wr && !rd_clr;
  endsequence
  sequence seq_mcol_event;
    clk_en && tx_frame_ok && tx_multi_collision && !mc_wr && !rd_clr;
  endsequence
  // Base-word read of the frame counter with both low lanes off, and no other cause
  sequence seq_txok_read_keep;
    clk_en && rd_take && a_base && a_sel == 2'h0 && a_lanes == 2'h0 && !tx_frame_ok && !ok_wr;
  endsequence

  // The captured value is the one that the clear discards
  chk_txok_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_txok_clear |=>
    (tx_ok_count_field == ETSA_CNT_RESET && hrdata[15:0] == $past(tx_ok_count_field)))
    else $error("frame counter not cleared by its read");
  chk_mcol_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_mcol_clear |=> (multi_collision_count_field == ETSA_CNT_RESET &&
    hrdata[15:0] == $past(multi_collision_count_field)))
    else $error("collision counter not cleared by its read");
  chk_read_keep: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_txok_read_keep |=> $stable(tx_ok_count_field))
    else $error("read without low lanes cleared counter");
  chk_txok_count: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_txok_event |=> tx_ok_count_field == $past(tx_ok_count_field) + 1'b1)
    else $error("good frame not counted");
  chk_mcol_count: assert property (@(posedge hclk) disable iff (!hresetn)
    seq_mcol_event |=> multi_collision_count_field == $past(multi_collision_count_field) + 1'b1)
    else $error("collision frame not counted");

  // Alias operations on the station address
  chk_clr_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (sa_wr && !strap_pending && op == ETSA_OP_CLR) |=>
    ((station_address_mid & $past(wdat & msk)) == 16'h0000))
    else $error("clear alias did not clear bits");
  chk_inv_alias: assert property (@(posedge hclk) disable iff (!hresetn)
    (sa_wr && !strap_pending && op == ETSA_OP_INV) |=>
    (station_address_mid == ($past(station_address_mid) ^ $past(wdat & msk))))
    else $error("invert alias did not toggle bits");

  // Refused accesses of the station address
  chk_byte_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && rd_take && a_sel == 2'h2 && hsize == ETSA_SIZE_BYTE) |=> hrdata == 32'h0000_0000)
    else $error("byte read of station address not zero");
  chk_upper_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_cyc && sel == 2'h2 && lanes == 2'h0 && !strap_pending) |=> $stable(station_address_mid))
    else $error("upper half write changed station address");
endmodule
`default_nettype wire

// >>> design/etsa_stat_counter.sv
// One self-clearing 16-bit transmit statistics counter
`default_nettype none
module etsa_stat_counter
  import etsa_pkg::*;
#(
  parameter int WIDTH = ETSA_FIELD_W
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  input  wire logic             count_evt,
  input  wire logic             wr_en,
  input  wire etsa_op_t         wr_op,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [WIDTH-1:0] wr_mask,
  input  wire logic             rd_clear,
  output logic      [WIDTH-1:0] count
);
  // Elaboration check: alias masks and clear logic assume a 16-bit field
  if (WIDTH != ETSA_FIELD_W) begin : g_bad_width
    $error("etsa_stat_counter: WIDTH must be 16");
  end

  logic [WIDTH-1:0] next_count;

  // Software write wins over a count in the same cycle; read-clear beats both
  always_comb begin
    next_count = count;
    if (rd_clear) begin
      next_count = '0;
    end else if (wr_en) begin
      next_count = etsa_apply(count, wr_data, wr_mask, wr_op);
    end else if (count_evt) begin
      next_count = count + 1'b1; // Wraps naturally
    end
  end

  // Counter state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= ETSA_CNT_RESET;
    end else if (clk_en) begin
      count <= next_count;
    end
  end

  chk_count_step: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && count_evt && !wr_en && !rd_clear) |=> count == $past(count) + 1'b1)
    else $error("counter did not advance on event");
  chk_clear_read: assert property (@(posedge hclk) disable iff (!hresetn)
    (clk_en && rd_clear) |=> count == '0)
    else $error("counter not cleared after read");
  chk_hold_idle: assert property (@(posedge hclk) disable iff (!hresetn)
    (!(clk_en && (count_evt || wr_en || rd_clear))) |=> $stable(count))
    else $error("counter changed without cause");
endmodule
`default_nettype wire

// >>> test/etsa_testbench.sv
// Self-checking testbench for the transmit statistics and station address block
`default_nettype none
module testbench import etsa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] FACT = 16'hc3a5; // Arbitrary factory address
  logic        hclk = 1'b0;
  logic        hresetn;
  logic        clk_en;
  logic        hsel;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        fa_valid;
  logic        tx_ok;
  logic        tx_mc;
  logic [7:0]  oct3;
  logic [7:0]  oct4;
  int          bad_count;
  int          samples_checked;

  // Single slave, so its ready is the bus ready
  etsa_regs dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .factory_addr_valid(fa_valid), .factory_addr(FACT), .tx_frame_ok(tx_ok),
    .tx_multi_collision(tx_mc), .addr_octet_third(oct3), .addr_octet_fourth(oct4));

  always #2.5 hclk = ~hclk;

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Bounded wait so a stuck ready cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask

  // One AHB-Lite single transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    htrans <= ETSA_TRANS_NONSEQ;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, ETSA_SIZE_WORD, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
    logic [31:0] r;
    bus(a, 1'b0, ETSA_SIZE_WORD, 32'h0, r);
    check(r, want);
  endtask

  // Frame completion pulses, with or without the multi-collision mark
  task automatic frames(input int n, input logic mc);
    repeat (n) begin
      tx_ok <= 1'b1;
      tx_mc <= mc;
      @(posedge hclk);
      tx_ok <= 1'b0;
      tx_mc <= 1'b0;
      @(posedge hclk);
    end
  endtask

  task automatic s_reset();
    rd_chk(ETSA_OFS_TXOK, 32'h0);
    rd_chk(ETSA_OFS_MCOL, 32'h0);
    rd_chk(ETSA_OFS_SADDR, {16'h0, FACT});
    check({24'h0, oct4}, {24'h0, FACT[15:8]});
    check({24'h0, oct3}, {24'h0, FACT[7:0]});
  endtask

  task automatic s_count();
    logic [31:0] r;
    frames(3, 1'b0);
    frames(2, 1'b1);
    rd_chk(ETSA_OFS_TXOK, 32'h5);
    rd_chk(ETSA_OFS_TXOK, 32'h0);
    rd_chk(ETSA_OFS_MCOL, 32'h2);
    rd_chk(ETSA_OFS_MCOL, 32'h0);
    // Upper halfword read leaves bytes 0/1 unselected, so no clear
    frames(1, 1'b0);
    bus(ETSA_OFS_TXOK + 8'h2, 1'b0, ETSA_SIZE_HALF, 32'h0, r);
    check({16'h0, r[31:16]}, 32'h0);
    rd_chk(ETSA_OFS_TXOK, 32'h1);
  endtask

  task automatic s_alias();
    logic [31:0] r;
    wr(ETSA_OFS_SADDR, 32'hffff_1234);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_1234);
    wr(ETSA_OFS_SADDR + ETSA_ALIAS_SET, 32'h0000_00c0);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_12f4);
    wr(ETSA_OFS_SADDR + ETSA_ALIAS_CLR, 32'h0000_1004);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_02f0);
    wr(ETSA_OFS_SADDR + ETSA_ALIAS_INV, 32'h0000_0ff0);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_0d00);
    check({16'h0, oct4, oct3}, 32'h0000_0d00);
    bus(ETSA_OFS_SADDR, 1'b1, ETSA_SIZE_BYTE, 32'h5555_5555, r);
    check({31'h0, hresp}, 32'h0);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_0d00);
    bus(ETSA_OFS_SADDR, 1'b0, ETSA_SIZE_BYTE, 32'h0, r);
    check(r, 32'h0);
    bus(ETSA_OFS_SADDR, 1'b1, ETSA_SIZE_HALF, 32'h0000_beef, r);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_beef);
    bus(ETSA_OFS_SADDR + 8'h2, 1'b1, ETSA_SIZE_HALF, 32'h1111_0000, r);
    rd_chk(ETSA_OFS_SADDR, 32'h0000_beef);
  endtask

  // Wrap from all ones, counter alias, and an unmapped word
  task automatic s_wrap();
    wr(ETSA_OFS_TXOK + ETSA_ALIAS_SET, 32'h0000_ffff);
    frames(1, 1'b0);
    rd_chk(ETSA_OFS_TXOK, 32'h0);
    wr(ETSA_OFS_MCOL + ETSA_ALIAS_SET, 32'hffff_0101);
    rd_chk(ETSA_OFS_MCOL, 32'h0000_0101);
    rd_chk(8'h30, 32'h0);
  endtask

  initial begin
    hresetn = 1'b0;
    clk_en = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = ETSA_SIZE_WORD;
    hwdata = 32'h0;
    fa_valid = 1'b1;
    tx_ok = 1'b0;
    tx_mc = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    s_reset();
    s_count();
    s_alias();
    s_wrap();
    give_verdict();
  end
endmodule
`default_nettype wire
